// file: hw/spicf_pkg.sv
// shared constants and carrier types of the serial port block
package spicf_pkg;
    // register word addresses
    localparam logic [1:0] SPICF_A_CON1 = 2'h0;
    localparam logic [1:0] SPICF_A_CON2 = 2'h1;
    localparam logic [1:0] SPICF_A_BUF = 2'h2;
    localparam logic [1:0] SPICF_A_STAT = 2'h3;
    // implemented bits and reset values
    localparam logic [15:0] SPICF_CON1_MASK = 16'h1FFF;
    localparam logic [15:0] SPICF_CON2_MASK = 16'hE003;
    localparam logic [15:0] SPICF_CON_RST = 16'h0000;
    // first control register fields
    localparam int SPICF_B_CLKDIS = 12;
    localparam int SPICF_B_DODIS = 11;
    localparam int SPICF_B_W16 = 10;
    localparam int SPICF_B_SMP = 9;
    localparam int SPICF_B_CKE = 8;
    localparam int SPICF_B_SELECT_PIN_ENABLE = 7;
    localparam int SPICF_B_CKP = 6;
    localparam int SPICF_B_MST = 5;
    localparam int SPICF_B_SEC = 2;
    localparam int SPICF_B_PRI = 0;
    // second control register fields
    localparam int SPICF_B_FRM = 15;
    localparam int SPICF_B_FSD = 14;
    localparam int SPICF_B_FPOL = 13;
    localparam int SPICF_B_FSE = 1;
    localparam int SPICF_B_BEN = 0;
    // status register fields
    localparam int SPICF_B_EN = 15;
    localparam int SPICF_B_ROV = 6;
    localparam int SPICF_B_RXE = 5;
    localparam int SPICF_B_TBF = 1;
    localparam int SPICF_B_RBF = 0;
    // deep buffer entries, then clock edges per 8 and 16 bit word
    localparam int SPICF_DEPTH = 4;
    localparam logic [5:0] SPICF_EDGES8 = 6'h10;
    localparam logic [5:0] SPICF_EDGES16 = 6'h20;

    typedef struct packed {
        logic [1:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } spicf_req_s;

    typedef struct packed {
        logic sck;
        logic sck_oe_n;
        logic sdo;
        logic sdo_oe_n;
        logic ss;
        logic ss_oe_n;
    } spicf_pins_s;

    localparam spicf_pins_s SPICF_PINS_RST = '{sck: 1'b0, sck_oe_n: 1'b1,
        sdo: 1'b0, sdo_oe_n: 1'b1, ss: 1'b0, ss_oe_n: 1'b1};
endpackage : spicf_pkg

// file: hw/spicf_prescale.sv
// two-stage serial clock prescaler producing lead and trail edge enables
`timescale 1ns/10ps
`default_nettype none
module spicf_prescale import spicf_pkg::*; (
    input wire logic clk, // system clock
    input wire logic rstn, // async reset, low
    input wire logic run, // count while high
    input wire logic [1:0] pri, // primary code
    input wire logic [2:0] sec, // secondary code
    output logic lead, // idle to active edge enable
    output logic trail // active to idle edge enable
);
    typedef struct packed {
        logic [9:0] cnt;
        logic [9:0] gap;
    } spicf_ps_s;

    spicf_ps_s s;
    spicf_ps_s n;
    logic [9:0] ratio;

    // code 11 is 1:1 up to 00 at 64:1; code 111 is 1:1 down to 000 at 8:1
    assign ratio = 10'((10'h001 << (2 * (3 - pri))) * (4'h8 - {1'b0, sec}));
    assign lead = run && (s.cnt == 10'h000);
    // a total ratio of 1 puts both edges in one cycle and is not usable
    assign trail = run && (s.cnt == (ratio >> 1));

    always_comb begin
        n = s;
        if (!run || (s.cnt >= ratio - 10'h001)) begin
            n.cnt = 10'h000;
        end else begin
            n.cnt = s.cnt + 10'h001;
        end
        if (!run) begin
            n.gap = 10'h000;
        end else if (lead) begin
            n.gap = 10'h001;
        end else if (s.gap != 10'h3FF && s.gap != 10'h000) begin
            n.gap = s.gap + 10'h001;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    property p_ratio;
        @(posedge clk) disable iff (!rstn)
        (lead && s.gap != 10'h000 && $stable(ratio)) |-> (s.gap == ratio);
    endproperty
    a_ratio: assert property (p_ratio) else $error("serial clock period wrong");
endmodule : spicf_prescale
`default_nettype wire

// file: hw/spicf_core.sv
// serial port configuration, clocking, framing and shared buffer logic
//
// Our own choices: strobed register access and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module spicf_core import spicf_pkg::*; (
    input wire logic clk, // system clock
    input wire logic rstn, // async reset, low
    input wire spicf_req_s req, // register request
    output logic [15:0] rdata, // read data, cycle after strobe
    input wire logic sck_i, // clock pin level
    input wire logic sdi_i, // data in pin
    input wire logic ss_i, // select or sync pin level
    output spicf_pins_s pins // pin drives and enables
);
    typedef struct packed {
        logic [15:0] con1;
        logic [15:0] con2;
        logic en;
        logic rov;
        logic [15:0] rdata;
        logic [SPICF_DEPTH-1:0][15:0] txq;
        logic [1:0] tx_wp;
        logic [1:0] tx_rp;
        logic [2:0] tx_cnt;
        logic [SPICF_DEPTH-1:0][15:0] rxq;
        logic [1:0] rx_wp;
        logic [1:0] rx_rp;
        logic [2:0] rx_cnt;
        logic [15:0] sr_tx;
        logic [15:0] sr_rx;
        logic busy;
        logic pre;
        logic loaded;
        logic [5:0] e;
        logic [2:0] sync1;
        logic [2:0] sync2;
        logic sck_d;
        spicf_pins_s pins;
    } spicf_st_s;

    spicf_st_s s;
    spicf_st_s n;

    logic w16, mst, cke, input_sample_phase, clock_polarity, framed, fsd, fpol, fse;
    logic [2:0] cap;
    logic [5:0] lastb;
    logic tx_full, rx_full, sck_s, sdi_s, ss_s, sync_in;
    logic slv_lead, slv_trail, slv_sel, lead, trail;
    logic tx_push, tx_pop, rx_push, rx_pop, ovf_evt, rov_clr, sync_out;
    logic [15:0] stat_w, rx_word;

    function automatic logic msb_of(input logic [15:0] v, input logic w);
        return w ? v[15] : v[7];
    endfunction : msb_of

    assign w16 = s.con1[SPICF_B_W16];
    assign mst = s.con1[SPICF_B_MST];
    assign input_sample_phase = s.con1[SPICF_B_SMP];
    assign clock_polarity = s.con1[SPICF_B_CKP];
    assign framed = s.con2[SPICF_B_FRM];
    assign fsd = s.con2[SPICF_B_FSD];
    assign fpol = s.con2[SPICF_B_FPOL];
    assign fse = s.con2[SPICF_B_FSE];
    // edge select is meaningless when framed, so it is forced off there
    assign cke = s.con1[SPICF_B_CKE] & ~framed;
    assign cap = s.con2[SPICF_B_BEN] ? 3'(SPICF_DEPTH) : 3'h1;
    assign lastb = w16 ? SPICF_EDGES16 : SPICF_EDGES8;
    assign tx_full = s.tx_cnt >= cap;
    assign rx_full = s.rx_cnt >= cap;
    assign sck_s = s.sync2[0];
    assign sdi_s = s.sync2[1];
    assign ss_s = s.sync2[2];
    assign sync_in = (ss_s == fpol);
    assign slv_lead = (sck_s != clock_polarity) && (s.sck_d == clock_polarity);
    assign slv_trail = (sck_s == clock_polarity) && (s.sck_d != clock_polarity);
    // framed slave without a sync input has nothing to qualify its clock
    assign slv_sel = framed ? (!fsd || s.busy || sync_in)
        : (!s.con1[SPICF_B_SELECT_PIN_ENABLE] || !ss_s);
    assign rdata = s.rdata;
    assign pins = s.pins;

    spicf_prescale u_prescale (
        .clk(clk),
        .rstn(rstn),
        .run(s.en && mst && s.busy),
        .pri(s.con1[SPICF_B_PRI +: 2]),
        .sec(s.con1[SPICF_B_SEC +: 3]),
        .lead(lead),
        .trail(trail)
    );

    always_comb begin
        n = s;
        tx_push = 1'b0;
        tx_pop = 1'b0;
        rx_push = 1'b0;
        rx_pop = 1'b0;
        ovf_evt = 1'b0;
        rov_clr = 1'b0;
        stat_w = 16'h0000;
        stat_w[SPICF_B_EN] = s.en;
        stat_w[SPICF_B_ROV] = s.rov;
        stat_w[SPICF_B_RXE] = (s.rx_cnt == 3'h0);
        stat_w[SPICF_B_TBF] = tx_full;
        stat_w[SPICF_B_RBF] = rx_full;
        n.sync1 = {ss_i, sdi_i, sck_i};
        n.sync2 = s.sync1;
        n.sck_d = sck_s;

        // register port: read data stand for one cycle only
        n.rdata = 16'h0000;
        if (req.rd) begin
            unique case (req.addr)
                SPICF_A_CON1: n.rdata = s.con1 & SPICF_CON1_MASK;
                SPICF_A_CON2: n.rdata = s.con2 & SPICF_CON2_MASK;
                SPICF_A_BUF: begin
                    n.rdata = s.rxq[s.rx_rp];
                    rx_pop = (s.rx_cnt != 3'h0);
                end
                SPICF_A_STAT: n.rdata = stat_w;
            endcase
        end
        if (req.wr) begin
            unique case (req.addr)
                SPICF_A_CON1: n.con1 = req.wdata & SPICF_CON1_MASK;
                SPICF_A_CON2: n.con2 = req.wdata & SPICF_CON2_MASK;
                SPICF_A_BUF: tx_push = !tx_full;
                SPICF_A_STAT: begin
                    n.en = req.wdata[SPICF_B_EN];
                    rov_clr = !req.wdata[SPICF_B_ROV];
                end
            endcase
        end

        rx_word = 16'h0000;
        if (!s.en) begin
            n.busy = 1'b0;
            n.pre = 1'b0;
            n.loaded = 1'b0;
            n.e = 6'h00;
        end else if (mst) begin
            if (!s.busy) begin
                n.pins.sck = clock_polarity;
                if (s.tx_cnt != 3'h0 && (!framed || !fsd || sync_in)) begin
                    n.sr_tx = s.txq[s.tx_rp];
                    tx_pop = 1'b1;
                    n.busy = 1'b1;
                    n.e = 6'h00;
                    n.pre = framed & ~fsd & ~fse;
                    if (cke) begin
                        n.pins.sdo = msb_of(n.sr_tx, w16);
                        n.sr_tx = n.sr_tx << 1;
                    end
                end
            end else if (lead || trail) begin
                if (s.pre) begin
                    // a spare bit period carries the leading sync pulse
                    n.pins.sck = lead ? ~clock_polarity : clock_polarity;
                    if (trail) begin
                        n.pre = 1'b0;
                    end
                end else begin
                    if (s.e < lastb) begin
                        n.pins.sck = s.e[0] ? clock_polarity : ~clock_polarity;
                    end
                    if (s.e < lastb && s.e[0] == cke) begin
                        n.pins.sdo = msb_of(s.sr_tx, w16);
                        n.sr_tx = s.sr_tx << 1;
                    end
                    if (input_sample_phase ? (s.e != 6'h00 && s.e[0] == cke)
                        : (s.e < lastb && s.e[0] != cke)) begin
                        n.sr_rx = {s.sr_rx[14:0], sdi_s};
                    end
                    // one extra tick closes the last bit for end sampling
                    if (s.e == lastb) begin
                        n.busy = 1'b0;
                        rx_push = 1'b1;
                    end
                    n.e = s.e + 6'h01;
                end
            end
        end else begin
            if (framed && fsd && sync_in) begin
                n.busy = 1'b1;
            end
            if (!slv_sel) begin
                // deselect mid-word drops the partial word
                n.e = 6'h00;
                n.loaded = 1'b0;
                n.busy = 1'b0;
            end else begin
                if (!s.loaded && s.tx_cnt != 3'h0 && s.e == 6'h00) begin
                    n.sr_tx = s.txq[s.tx_rp];
                    tx_pop = 1'b1;
                    n.loaded = 1'b1;
                    if (cke) begin
                        n.pins.sdo = msb_of(n.sr_tx, w16);
                        n.sr_tx = n.sr_tx << 1;
                    end
                end
                if (cke ? slv_trail : slv_lead) begin
                    n.pins.sdo = msb_of(n.sr_tx, w16);
                    n.sr_tx = n.sr_tx << 1;
                end
                if (cke ? slv_lead : slv_trail) begin
                    n.sr_rx = {s.sr_rx[14:0], sdi_s};
                    if (s.e == (lastb >> 1) - 6'h01) begin
                        rx_push = 1'b1;
                        n.e = 6'h00;
                        n.loaded = 1'b0;
                        n.busy = 1'b0;
                    end else begin
                        n.e = s.e + 6'h01;
                    end
                end
            end
        end

        if (rx_push) begin
            rx_word = w16 ? n.sr_rx : {8'h00, n.sr_rx[7:0]};
        end
        // a full receive side keeps the unread word and drops the new one
        ovf_evt = rx_push && rx_full;
        if (rx_push && !rx_full) begin
            n.rxq[s.rx_wp] = rx_word;
            n.rx_wp = s.rx_wp + 2'h1;
        end
        if (rx_pop) begin
            n.rx_rp = s.rx_rp + 2'h1;
        end
        n.rx_cnt = 3'(s.rx_cnt + {2'b00, rx_push && !rx_full}
            - {2'b00, rx_pop});
        if (tx_push) begin
            n.txq[s.tx_wp] = req.wdata;
            n.tx_wp = s.tx_wp + 2'h1;
        end
        if (tx_pop) begin
            n.tx_rp = s.tx_rp + 2'h1;
        end
        n.tx_cnt = 3'(s.tx_cnt + {2'b00, tx_push} - {2'b00, tx_pop});
        // a hardware overflow beats a software clear in the same cycle
        n.rov = ovf_evt | (s.rov & ~rov_clr);
        if (!n.en) begin
            n.tx_cnt = 3'h0;
            n.tx_wp = 2'h0;
            n.tx_rp = 2'h0;
            n.rx_cnt = 3'h0;
            n.rx_wp = 2'h0;
            n.rx_rp = 2'h0;
        end

        if (mst) begin
            sync_out = n.pre | (fse & n.busy & (n.e < 6'h02));
        end else begin
            sync_out = n.loaded & (n.e == 6'h00);
        end
        n.pins.ss = fpol ? sync_out : ~sync_out;
        n.pins.ss_oe_n = !(s.en && framed && !fsd);
        n.pins.sck_oe_n = !(s.en && mst && !s.con1[SPICF_B_CLKDIS]);
        n.pins.sdo_oe_n = !(s.en && !s.con1[SPICF_B_DODIS]
            && (mst || slv_sel));
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s <= '0;
            s.con1 <= SPICF_CON_RST;
            s.con2 <= SPICF_CON_RST;
            s.pins <= SPICF_PINS_RST;
        end else begin
            s <= n;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    sequence s_buf_wr;
        req.wr && req.addr == SPICF_A_BUF && s.en && mst && !framed
            && !s.busy && s.tx_cnt == 3'h0;
    endsequence

    sequence s_quiet;
        !req.wr;
    endsequence

    property p_clk_disable;
        s.con1[SPICF_B_CLKDIS] |=> pins.sck_oe_n;
    endproperty
    a_clk_disable: assert property (p_clk_disable)
        else $error("clock pin driven while disabled");

    property p_dout_disable;
        (s.con1[SPICF_B_DODIS] || !s.en) |=> pins.sdo_oe_n;
    endproperty
    a_dout_disable: assert property (p_dout_disable)
        else $error("data pin driven while disabled");

    property p_frame_len;
        ($fell(s.busy) && $past(s.en) && $past(mst) && s.en)
            |-> ($past(s.e) == ($past(w16) ? SPICF_EDGES16 : SPICF_EDGES8));
    endproperty
    a_frame_len: assert property (p_frame_len)
        else $error("master word length wrong");

    property p_idle_pol;
        (s.en && mst && !s.busy) |=> (pins.sck == $past(clock_polarity));
    endproperty
    a_idle_pol: assert property (p_idle_pol)
        else $error("idle clock level wrong");

    property p_start;
        s_buf_wr ##1 s_quiet |=> s.busy;
    endproperty
    a_start: assert property (p_start)
        else $error("transfer did not start after buffer write");

    property p_overflow;
        (ovf_evt && !rx_pop) |=> (s.rov && $stable(s.rx_cnt));
    endproperty
    a_overflow: assert property (p_overflow)
        else $error("overflow not flagged or word kept");

    property p_reserved;
        (req.rd && req.addr == SPICF_A_CON2)
            |=> ((s.rdata & ~SPICF_CON2_MASK) == 16'h0000);
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("unused control bits read nonzero");

    property p_bufread;
        (req.rd && req.addr == SPICF_A_BUF)
            |=> (s.rdata == $past(s.rxq[s.rx_rp]));
    endproperty
    a_bufread: assert property (p_bufread)
        else $error("buffer read did not return receive head");
endmodule : spicf_core
`default_nettype wire

// file: sim/spicf_far_slave.sv
// far side serial slave model: sends a loaded word, captures the incoming one
`timescale 1ns/10ps
`default_nettype none
module spicf_far_slave (
    input wire logic sck, // serial clock from the block
    input wire logic sdo, // data from the block
    input wire logic cpol, // clock idle level
    input wire logic trail_chg, // block changes data on the trailing edge
    input wire logic load, // rising edge loads tx_word
    input wire logic [15:0] tx_word, // word to send, left aligned
    output logic sdi, // data towards the block
    output logic [15:0] rx_word // last bits captured
);
    logic [15:0] sh;
    logic got;

    assign sdi = sh[15];

    // lead and trail are told apart by the idle level
    always @(posedge load or posedge sck or negedge sck) begin
        if (load) begin
            sh <= tx_word;
            got <= 1'b0;
        end else if ((sck != cpol) == trail_chg) begin
            rx_word <= {rx_word[14:0], sdo};
            got <= 1'b1;
        end else if (got) begin
            // spent bits come back inverted so a stale line never matches
            sh <= {sh[14:0], ~sh[15]};
        end
    end
endmodule : spicf_far_slave
`default_nettype wire

// file: sim/spi_config_clock_framing_bench.sv
// self-checking bench for the serial port configuration block
`timescale 1ns/10ps
`default_nettype none
module spi_config_clock_framing_bench import spicf_pkg::*;;
    logic clk;
    logic rstn;
    spicf_req_s req;
    logic [15:0] rdata;
    spicf_pins_s pins;
    logic sdi;
    logic cpol;
    logic trail_chg;
    logic pload;
    logic [15:0] ptx;
    logic [15:0] prx;
    logic ss_lead;
    logic ext_sck;
    logic ext_ss;
    logic [15:0] d;
    int n_fail;
    int checks;
    logic [15:0] pc [6] = '{16'h003E, 16'h0023, 16'h003B, 16'h002F,
        16'h003D, 16'h003C};
    int pn [6] = '{4, 8, 2, 5, 16, 64};

    // a released pin shows the far side's level; the select idles high
    spicf_core i_dut (
        .clk(clk),
        .rstn(rstn),
        .req(req),
        .rdata(rdata),
        .sck_i(pins.sck_oe_n ? ext_sck : pins.sck),
        .sdi_i(sdi),
        .ss_i(pins.ss_oe_n ? ext_ss : pins.ss),
        .pins(pins)
    );

    spicf_far_slave i_far (
        .sck(pins.sck_oe_n ? ext_sck : pins.sck),
        .sdo(pins.sdo_oe_n ? 1'b1 : pins.sdo),
        .cpol(cpol),
        .trail_chg(trail_chg),
        .load(pload),
        .tx_word(ptx),
        .sdi(sdi),
        .rx_word(prx)
    );

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic finish_test;
        if (n_fail == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input string what, input logic [15:0] seen,
            input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic chkb(input string what, input logic seen, input logic exp);
        chk(what, {15'h0000, seen}, {15'h0000, exp});
    endtask : chkb

    // each access leaves one idle edge so strobes never stack in one step
    task automatic wr(input logic [1:0] a, input logic [15:0] v);
        @(posedge clk);
        req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        req <= '{addr: a, wdata: v, wr: 1'b0, rd: 1'b0};
    endtask : wr

    task automatic rd(input logic [1:0] a, output logic [15:0] v);
        @(posedge clk);
        req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b0};
        #1;
        v = rdata;
    endtask : rd

    task automatic settle;
        repeat (3) @(posedge clk);
        #1;
    endtask : settle

    task automatic pl(input logic [15:0] c1, input logic [15:0] w);
        @(posedge clk);
        cpol <= c1[SPICF_B_CKP];
        trail_chg <= c1[SPICF_B_CKE];
        ptx <= w;
        pload <= 1'b1;
        @(posedge clk);
        pload <= 1'b0;
    endtask : pl

    task automatic wait_stat(input int b, input logic v);
        logic [15:0] s;
        for (int i = 0; i < 1000; i++) begin
            rd(SPICF_A_STAT, s);
            if (s[b] === v) return;
        end
        chkb("status wait", s[b], v);
        finish_test();
    endtask : wait_stat

    task automatic xfer(input logic [15:0] c1, input logic [15:0] tx,
            input logic [15:0] rxw, input int n_exp, input bit dchk);
        int leads;
        int first;
        int last;
        int w;
        logic prev;
        logic [15:0] v;
        w = c1[SPICF_B_W16] ? 16 : 8;
        leads = 0;
        first = 0;
        last = 0;
        prev = 1'b0;
        wr(SPICF_A_CON1, c1);
        pl(c1, w == 16 ? rxw : {rxw[7:0], 8'h00});
        wr(SPICF_A_BUF, tx);
        for (int t = 0; t < 20000 && !(leads > 0 && t - last > 300); t++) begin
            @(posedge clk);
            #1;
            if ((pins.sck ^ cpol) && !prev) begin
                leads++;
                if (leads == 1) begin
                    first = t;
                    ss_lead = pins.ss;
                end
                if (leads == 2) begin
                    chk("sck period", 16'(t - first), 16'(n_exp));
                end
                last = t;
            end
            prev = pins.sck ^ cpol;
        end
        chk("clock count", 16'(leads), 16'(w));
        wait_stat(SPICF_B_RBF, 1'b1);
        rd(SPICF_A_BUF, v);
        if (dchk) begin
            chk("rx word", v, w == 16 ? rxw : {8'h00, rxw[7:0]});
        end
        chk("far rx", w == 16 ? prx : {8'h00, prx[7:0]},
            w == 16 ? tx : {8'h00, tx[7:0]});
    endtask : xfer

    initial begin
        req = '0;
        rstn = 1'b0;
        cpol = 1'b0;
        trail_chg = 1'b0;
        pload = 1'b0;
        ptx = 16'h0000;
        ss_lead = 1'b0;
        ext_sck = 1'b0;
        ext_ss = 1'b1;
        n_fail = 0;
        checks = 0;
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        rd(SPICF_A_CON1, d);
        chk("con1 reset", d, 16'h0000);
        rd(SPICF_A_CON2, d);
        chk("con2 reset", d, 16'h0000);
        wr(SPICF_A_CON1, 16'hFFFF);
        rd(SPICF_A_CON1, d);
        chk("con1 bits", d, 16'h1FFF);
        wr(SPICF_A_CON2, 16'hFFFF);
        rd(SPICF_A_CON2, d);
        chk("con2 bits", d, 16'hE003);
        wr(SPICF_A_CON2, 16'h0000);
        wr(SPICF_A_CON1, 16'h0000);
        wr(SPICF_A_STAT, 16'h8000);
        settle();
        chkb("slave clk oe", pins.sck_oe_n, 1'b1);
        wr(SPICF_A_CON1, 16'h0032);
        settle();
        chkb("master clk oe", pins.sck_oe_n, 1'b0);
        chkb("clk idle low", pins.sck, 1'b0);
        chkb("data oe", pins.sdo_oe_n, 1'b0);
        wr(SPICF_A_CON1, 16'h1832);
        settle();
        chkb("clk released", pins.sck_oe_n, 1'b1);
        chkb("data released", pins.sdo_oe_n, 1'b1);
        wr(SPICF_A_CON1, 16'h0072);
        settle();
        chkb("clk idle high", pins.sck, 1'b1);
        xfer(16'h0032, 16'h00A5, 16'h003C, 16, 1'b1);
        xfer(16'h0772, 16'hC3E1, 16'h5A96, 16, 1'b1);
        for (int i = 0; i < 6; i++) begin
            xfer(pc[i], 16'h0081, 16'h0042, pn[i], 1'b0);
        end
        // framing keeps the edge bit clear, as software must
        wr(SPICF_A_CON2, 16'hA002);
        settle();
        chkb("sync oe", pins.ss_oe_n, 1'b0);
        chkb("sync idle low", pins.ss, 1'b0);
        xfer(16'h0032, 16'h0096, 16'h0069, 16, 1'b1);
        chkb("sync at first clock", ss_lead, 1'b1);
        wr(SPICF_A_CON2, 16'h8000);
        settle();
        chkb("sync idle high", pins.ss, 1'b1);
        wr(SPICF_A_CON2, 16'hC000);
        settle();
        chkb("sync input", pins.ss_oe_n, 1'b1);
        wr(SPICF_A_CON2, 16'h0000);
        pl(16'h0032, 16'h5A00);
        wr(SPICF_A_BUF, 16'h0011);
        wait_stat(SPICF_B_RBF, 1'b1);
        wr(SPICF_A_BUF, 16'h0022);
        wait_stat(SPICF_B_ROV, 1'b1);
        rd(SPICF_A_BUF, d);
        chk("kept word", d, 16'h005A);
        wr(SPICF_A_STAT, 16'h8000);
        rd(SPICF_A_STAT, d);
        chkb("overflow cleared", d[SPICF_B_ROV], 1'b0);
        wr(SPICF_A_CON2, 16'h0001);
        pl(16'h0032, 16'h3300);
        for (int i = 0; i < 4; i++) begin
            wr(SPICF_A_BUF, 16'(i));
        end
        wait_stat(SPICF_B_RBF, 1'b1);
        rd(SPICF_A_STAT, d);
        chkb("deep no overflow", d[SPICF_B_ROV], 1'b0);
        rd(SPICF_A_BUF, d);
        chk("deep first word", d, 16'h0033);
        repeat (3) rd(SPICF_A_BUF, d);
        rd(SPICF_A_STAT, d);
        chkb("deep drained", d[SPICF_B_RXE], 1'b1);
        // slave with select enabled; the bench clocks the link slowly
        wr(SPICF_A_CON1, 16'h0080);
        settle();
        chkb("deselected data oe", pins.sdo_oe_n, 1'b1);
        pl(16'h0080, 16'hC600);
        wr(SPICF_A_BUF, 16'h0059);
        ext_ss <= 1'b0;
        settle();
        chkb("selected data oe", pins.sdo_oe_n, 1'b0);
        repeat (16) begin
            repeat (8) @(posedge clk);
            ext_sck <= ~ext_sck;
        end
        wait_stat(SPICF_B_RXE, 1'b0);
        rd(SPICF_A_BUF, d);
        chk("slave rx word", d, 16'h00C6);
        chk("slave far rx", {8'h00, prx[7:0]}, 16'h0059);
        finish_test();
    end
endmodule : spi_config_clock_framing_bench
`default_nettype wire
